// *** design/rcfr_event_decode.sv ***
`timescale 1ns/100ps
module rcfr_event_decode
  import rcfr_pkg::*;
(
  // Core event strobes
  input wire logic ev_bor,
  input wire logic ev_external_pin_reset_flag,
  input wire logic ev_swr,
  input wire logic ev_watchdog_expired_flag,
  input wire logic ev_trap,
  input wire logic ev_iop,
  input wire logic ev_cm,
  input wire logic ev_wdt_clear,
  input wire logic ev_psave,
  input wire logic ev_psave_op,
  // Decoded masks
  rcfr_evt_if.src evt
);
  // Per-event set and clear bits
  logic [15:0] set_w;
  logic [15:0] clr_w;
  always_comb begin
    set_w = RCFR_ZERO16;
    set_w[RCFR_BIT_BOR] = ev_bor; // [R2]
    set_w[RCFR_BIT_WATCHDOG_EXPIRED_FLAG] = ev_watchdog_expired_flag; // [R3]
    set_w[RCFR_BIT_SLEEP] = ev_psave && (ev_psave_op == RCFR_PSAVE_SLEEP); // [R4]
    set_w[RCFR_BIT_IDLE] = ev_psave && (ev_psave_op == RCFR_PSAVE_IDLE); // [R5]
    set_w[RCFR_BIT_TRAP] = ev_trap; // [R6]
    set_w[RCFR_BIT_IOP] = ev_iop; // [R6]
    set_w[RCFR_BIT_CM] = ev_cm; // [R6]
    set_w[RCFR_BIT_EXTERNAL_PIN_RESET_FLAG] = ev_external_pin_reset_flag; // [R7]
    set_w[RCFR_BIT_SWR] = ev_swr; // [R7]
    clr_w = RCFR_ZERO16;
    clr_w[RCFR_BIT_WATCHDOG_EXPIRED_FLAG] = ev_wdt_clear || ev_psave; // [R3]
  end
  assign evt.set_mask = set_w;
  assign evt.clr_mask = clr_w;
endmodule : rcfr_event_decode

// *** design/rcfr_evt_if.sv ***
`timescale 1ns/100ps
interface rcfr_evt_if;
  logic [15:0] set_mask;
  logic [15:0] clr_mask;
  modport src (output set_mask, output clr_mask);
  modport dst (input set_mask, input clr_mask);
endinterface : rcfr_evt_if

// *** design/rcfr_pkg.sv ***
package rcfr_pkg;
  // Register byte addresses (chosen, word aligned)
  localparam logic [4:0] RCFR_OFS_FLAGS = 5'h00;
  localparam logic [4:0] RCFR_OFS_CTRL = 5'h04;
  localparam logic [4:0] RCFR_OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] RCFR_OFS_IRQ_MASK = 5'h0c;
  localparam logic [4:0] RCFR_OFS_FUSE = 5'h10;
  localparam int RCFR_ADDR_W = 8;
  localparam logic [7:0] RCFR_ADDR_FLAGS = 8'h00;
  localparam logic [7:0] RCFR_ADDR_CTRL = 8'h04;
  localparam logic [7:0] RCFR_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] RCFR_ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] RCFR_ADDR_STATUS = 8'h10;
  // Flag bit positions in the reset-cause register
  localparam int RCFR_BIT_POR = 0;
  localparam int RCFR_BIT_BOR = 1;
  localparam int RCFR_BIT_IDLE = 2;
  localparam int RCFR_BIT_SLEEP = 3;
  localparam int RCFR_BIT_WATCHDOG_EXPIRED_FLAG = 4;
  localparam int RCFR_BIT_SWDT = 5;
  localparam int RCFR_BIT_SWR = 6;
  localparam int RCFR_BIT_EXTERNAL_PIN_RESET_FLAG = 7;
  localparam int RCFR_BIT_CM = 9;
  localparam int RCFR_BIT_IOP = 14;
  localparam int RCFR_BIT_TRAP = 15;
  // Control register bit positions
  localparam int RCFR_CTRL_SBOR = 0;
  localparam int RCFR_CTRL_RET = 1;
  // Implemented bits of the reset-cause register
  localparam logic [15:0] RCFR_FLAGS_MASK = 16'hc2ff;
  localparam logic [15:0] RCFR_FLAGS_RST = 16'h0003;
  localparam logic [15:0] RCFR_ZERO16 = 16'h0000;
  // Fuse codes
  localparam logic [1:0] RCFR_WDT_FUSE_ALWAYS = 2'h3;
  localparam logic [1:0] RCFR_BOR_FUSE_SOFT = 2'h1;
  // Power-save operands
  localparam logic RCFR_PSAVE_SLEEP = 1'b0;
  localparam logic RCFR_PSAVE_IDLE = 1'b1;
endpackage : rcfr_pkg

// *** design/rcfr_top.sv ***
// Functional notes
// [R1] A power-on reset sets the power-on flag at bit 0, which stays until software clears it.
// [R2] The brown-out flag at bit 1 is set by a brown-out reset and also by a power-on reset.
// [R3] The watchdog flag at bit 4 is set on expiry and cleared by watchdog-clear, power-save or power-on.
// [R4] The sleep flag at bit 3 is set by power-save with operand 0 and only power-on clears it in hardware.
// [R5] The idle flag at bit 2 is set by power-save with operand 1 and only power-on clears it in hardware.
// [R6] Trap conflict (15), bad opcode (14) and config mismatch (9) flags set on their events, cleared by power-on.
// [R7] Pin reset (7) and reset instruction (6) flags set on their events, cleared in hardware only by power-on.
// [R8] Software may set or clear every flag, and such a write never causes a reset.
// [R9] Writing bit 5 to one enables the watchdog, writing zero disables it.
// [R10] With watchdog fuse 11 the watchdog always runs and the software bit is ignored.
// [R11] The software brown-out enable works only when the brown-out fuse field is 01.
// [R12] Low-power fuse 1 keeps the retention regulator off; retention keeps SRAM during sleep.
// [R13] Each flag is sticky; the reset it records does not clear it.
`timescale 1ns/100ps
module rcfr_top
  import rcfr_pkg::*;
(
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [rcfr_pkg::RCFR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Reset and core event strobes, one cycle each
  input wire logic ev_bor,
  input wire logic ev_external_pin_reset_flag,
  input wire logic ev_swr,
  input wire logic ev_watchdog_expired_flag,
  input wire logic ev_trap,
  input wire logic ev_iop,
  input wire logic ev_cm,
  input wire logic ev_wdt_clear,
  input wire logic ev_psave,
  input wire logic ev_psave_op,
  // Configuration fuses, static
  input wire logic [1:0] watchdog_enable_fuse,
  input wire logic [1:0] brownout_config_fuse,
  input wire logic low_power_fuse,
  // Enables toward the analog and timer blocks
  output logic watchdog_run,
  output logic brownout_run,
  output logic retention_run,
  output logic sram_hold_in_sleep,
  // Interrupt
  output logic irq
);
  import rcfr_pkg::*;

  // Address match; every register select uses the same compare
  function automatic logic rcfr_hit(input logic [RCFR_ADDR_W-1:0] addr, input logic [RCFR_ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : rcfr_hit

  // Implemented flag bits only; the holes read zero and ignore writes
  function automatic logic [15:0] rcfr_impl(input logic [15:0] value);
    return value & RCFR_FLAGS_MASK;
  endfunction : rcfr_impl

  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // Event decoding sits in its own module
  rcfr_evt_if evt ();
  rcfr_event_decode rcfr_event_decode_inst (
    .ev_bor(ev_bor),
    .ev_external_pin_reset_flag(ev_external_pin_reset_flag),
    .ev_swr(ev_swr),
    .ev_watchdog_expired_flag(ev_watchdog_expired_flag),
    .ev_trap(ev_trap),
    .ev_iop(ev_iop),
    .ev_cm(ev_cm),
    .ev_wdt_clear(ev_wdt_clear),
    .ev_psave(ev_psave),
    .ev_psave_op(ev_psave_op),
    .evt(evt)
  );

  // Fuses are static straps; sample them through two stages anyway
  logic [4:0] fuse_meta_r;
  logic [4:0] fuse_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_meta_r <= 5'h00;
      fuse_r <= 5'h00;
    end else begin
      fuse_meta_r <= {low_power_fuse, brownout_config_fuse, watchdog_enable_fuse};
      fuse_r <= fuse_meta_r;
    end
  end
  wire [1:0] wdt_fuse = fuse_r[1:0];
  wire [1:0] bor_fuse = fuse_r[3:2];
  wire lp_fuse = fuse_r[4];

  // Address decode
  wire sel_flags = rcfr_hit(reg_addr, RCFR_ADDR_FLAGS);
  wire sel_ctrl = rcfr_hit(reg_addr, RCFR_ADDR_CTRL);
  wire sel_stat = rcfr_hit(reg_addr, RCFR_ADDR_IRQ_STAT);
  wire sel_mask = rcfr_hit(reg_addr, RCFR_ADDR_IRQ_MASK);
  wire sel_status = rcfr_hit(reg_addr, RCFR_ADDR_STATUS);
  wire wr_flags = reg_wr && sel_flags;
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_mask = reg_wr && sel_mask;
  wire rd_stat = reg_rd && sel_stat;

  // Reset-cause flags: power-on loads POR and BOR, everything else zero
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;
  assign hw_set = rcfr_impl(evt.set_mask);
  assign hw_clr = rcfr_impl(evt.clr_mask);
  // Software write first, then hardware clear, hardware set wins last
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = rcfr_impl(reg_wdata); // [R8]
    end
    flags_nxt = flags_nxt & ~hw_clr; // [R3]
    flags_nxt = flags_nxt | hw_set; // [R13]
  end
  // Only the power-on reset reloads these; of the events only watchdog-clear and power-save clear one, bit 4
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= RCFR_FLAGS_RST; // [R1] [R2] [R6] [R7]
    end else begin
      flags_r <= flags_nxt; // [R4] [R5]
    end
  end

  // Control: software brown-out and retention enables
  logic [1:0] ctrl_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 2'h0;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  // Derived enables; fuses override software bits
  wire wdt_soft = flags_r[RCFR_BIT_SWDT]; // [R9]
  wire wdt_en = (wdt_fuse == RCFR_WDT_FUSE_ALWAYS) ? 1'b1 : wdt_soft; // [R10]
  wire bor_en = (bor_fuse == RCFR_BOR_FUSE_SOFT) && ctrl_r[RCFR_CTRL_SBOR]; // [R11]
  wire ret_en = !lp_fuse && ctrl_r[RCFR_CTRL_RET]; // [R12]

  // Interrupt status: any newly recorded cause; read clears, set wins
  logic [15:0] istat_r;
  logic [15:0] imask_r;
  logic [15:0] istat_nxt;
  assign istat_nxt = (rd_stat ? RCFR_ZERO16 : istat_r) | hw_set;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= RCFR_ZERO16;
    end else begin
      istat_r <= istat_nxt;
    end
  end
  // Mask changes only on a software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      imask_r <= RCFR_ZERO16;
    end else if (wr_mask) begin
      imask_r <= rcfr_impl(reg_wdata);
    end
  end

  // Read mux; unmapped addresses return zero
  wire [15:0] status_w = {11'h000, ret_en, bor_en, wdt_en, bor_fuse == RCFR_BOR_FUSE_SOFT, lp_fuse};
  wire [15:0] rd_mux = sel_flags ? flags_r :
                       sel_ctrl ? {14'h0000, ctrl_r} :
                       sel_stat ? istat_r :
                       sel_mask ? imask_r :
                       sel_status ? status_w : RCFR_ZERO16;

  // Read data valid only the cycle after the strobe, zero otherwise so buses can be OR-ed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RCFR_ZERO16;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RCFR_ZERO16;
    end
  end

  // Watchdog run level toward the timer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_run <= 1'b0;
    end else begin
      watchdog_run <= wdt_en; // [R9] [R10]
    end
  end

  // Brown-out detector enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_run <= 1'b0;
    end else begin
      brownout_run <= bor_en; // [R11]
    end
  end

  // Retention regulator enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      retention_run <= 1'b0;
    end else begin
      retention_run <= ret_en; // [R12]
    end
  end

  // SRAM hold has its own flop so the output comes straight from a register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_hold_in_sleep <= 1'b0;
    end else begin
      sram_hold_in_sleep <= ret_en; // [R12]
    end
  end

  // Interrupt uses next-state status so a cause shows in the cycle it lands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_nxt & imask_r);
    end
  end
endmodule : rcfr_top

// *** verification/rcfr_top_assertions.sv ***
`timescale 1ns/100ps
module rcfr_top_assertions
  import rcfr_pkg::*;
(
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [rcfr_pkg::RCFR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Event strobes
  input wire logic ev_watchdog_expired_flag,
  input wire logic ev_trap,
  input wire logic ev_external_pin_reset_flag,
  input wire logic ev_wdt_clear,
  input wire logic ev_psave,
  input wire logic ev_psave_op,
  // Fuses and enables
  input wire logic [1:0] watchdog_enable_fuse,
  input wire logic low_power_fuse,
  input wire logic watchdog_run,
  input wire logic retention_run
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Flag read; its answer lands one cycle later
  wire rd_flags = reg_rd && reg_addr == RCFR_ADDR_FLAGS;
  // Fuses pass two sync flops, so allow eight cycles of a steady fuse
  property p_wdt_fuse; (watchdog_enable_fuse == 2'h3) [*8] |-> watchdog_run; endproperty
  a_wdt_fuse: assert property (p_wdt_fuse) else $error("watchdog not forced on");
  property p_ret_fuse; low_power_fuse [*8] |-> !retention_run; endproperty
  a_ret_fuse: assert property (p_ret_fuse) else $error("retention not held off");
  // Event, one quiet bus cycle, then the flag read; nothing may touch the flag in between
  property p_watchdog_expired_flag_set; ev_watchdog_expired_flag ##1 (!reg_wr && !ev_wdt_clear && !ev_psave) ##1 rd_flags
    |=> reg_rdata[RCFR_BIT_WATCHDOG_EXPIRED_FLAG]; endproperty
  a_watchdog_expired_flag_set: assert property (p_watchdog_expired_flag_set) else $error("watchdog flag not set");
  property p_watchdog_expired_flag_clr; (ev_wdt_clear && !ev_watchdog_expired_flag && !reg_wr) ##1 (!ev_watchdog_expired_flag && !reg_wr) ##1 rd_flags
    |=> !reg_rdata[RCFR_BIT_WATCHDOG_EXPIRED_FLAG]; endproperty
  a_watchdog_expired_flag_clr: assert property (p_watchdog_expired_flag_clr) else $error("watchdog flag not cleared");
  property p_trap_set; ev_trap ##1 !reg_wr ##1 rd_flags |=> reg_rdata[RCFR_BIT_TRAP]; endproperty
  a_trap_set: assert property (p_trap_set) else $error("trap flag not set");
  property p_external_pin_reset_flag_set; ev_external_pin_reset_flag ##1 !reg_wr ##1 rd_flags |=> reg_rdata[RCFR_BIT_EXTERNAL_PIN_RESET_FLAG]; endproperty
  a_external_pin_reset_flag_set: assert property (p_external_pin_reset_flag_set) else $error("pin reset flag not set");
  property p_sleep; (ev_psave && ev_psave_op == RCFR_PSAVE_SLEEP) ##1 !reg_wr ##1 rd_flags
    |=> reg_rdata[RCFR_BIT_SLEEP]; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flag not set");
  property p_idle; (ev_psave && ev_psave_op == RCFR_PSAVE_IDLE) ##1 !reg_wr ##1 rd_flags
    |=> reg_rdata[RCFR_BIT_IDLE]; endproperty
  a_idle: assert property (p_idle) else $error("idle flag not set");
  property p_swdt; (reg_wr && reg_addr == 8'h00 && watchdog_enable_fuse != 2'h3) ##1 !reg_wr
    |=> watchdog_run == $past(reg_wdata[RCFR_BIT_SWDT], 2); endproperty
  a_swdt: assert property (p_swdt) else $error("watchdog run not following soft bit");
endmodule : rcfr_top_assertions

bind rcfr_top rcfr_top_assertions rcfr_top_assertions_inst (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .ev_watchdog_expired_flag, .ev_trap, .ev_external_pin_reset_flag, .ev_wdt_clear, .ev_psave, .ev_psave_op,
  .watchdog_enable_fuse, .low_power_fuse, .watchdog_run, .retention_run);

// *** verification/test_rcfr_top.sv ***
`timescale 1ns/100ps
module test_rcfr_top;
  import rcfr_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [8:0] ev = 9'h000; // bor external_pin_reset_flag swr watchdog_expired_flag trap iop cm wdt_clear psave
  logic psave_op = 1'b0;
  logic [1:0] wdt_fuse = 2'h0;
  logic [1:0] bor_fuse = 2'h1;
  logic lp_fuse = 1'b0;
  logic wdt_run, bor_run, ret_run, sram_hold, irq;
  int bad_count = 0;
  int n_compared = 0;
  always #25 core_clk = ~core_clk;
  rcfr_top rcfr_top_inst (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_bor(ev[0]), .ev_external_pin_reset_flag(ev[1]), .ev_swr(ev[2]),
    .ev_watchdog_expired_flag(ev[3]), .ev_trap(ev[4]), .ev_iop(ev[5]), .ev_cm(ev[6]), .ev_wdt_clear(ev[7]), .ev_psave(ev[8]),
    .ev_psave_op(psave_op), .watchdog_enable_fuse(wdt_fuse), .brownout_config_fuse(bor_fuse),
    .low_power_fuse(lp_fuse), .watchdog_run(wdt_run), .brownout_run(bor_run), .retention_run(ret_run),
    .sram_hold_in_sleep(sram_hold), .irq(irq));
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask : chk
  // Bus cycles; read data is looked at only in the cycle after the strobe
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] exp, input string nm, input logic [15:0] m = 16'hffff);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata & m);
  endtask : rd
  task pulse(input int i, input logic op = 1'b0);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    psave_op <= op;
    @(posedge core_clk);
    ev <= 9'h000;
  endtask : pulse
  // Levels seen at the enable outputs, packed for one compare
  function automatic logic [15:0] outs();
    return {12'h000, wdt_run, bor_run, ret_run, sram_hold};
  endfunction : outs
  task t_reset_values;
    rd(RCFR_ADDR_FLAGS, 16'h0003, "flags at reset");
    rd(RCFR_ADDR_CTRL, 16'h0000, "ctrl at reset");
  endtask : t_reset_values
  task t_event_flags;
    int pos[7] = '{1, 7, 6, 4, 15, 14, 9};
    logic [15:0] exp;
    wr(RCFR_ADDR_FLAGS, 16'h0000);
    rd(RCFR_ADDR_FLAGS, 16'h0000, "flags cleared");
    pulse(8, RCFR_PSAVE_SLEEP);
    rd(RCFR_ADDR_FLAGS, 16'h0008, "sleep flag");
    pulse(8, RCFR_PSAVE_IDLE);
    exp = 16'h000c;
    rd(RCFR_ADDR_FLAGS, exp, "idle flag");
    // Each flag must survive the later events of this loop
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      exp[pos[i]] = 1'b1;
      rd(RCFR_ADDR_FLAGS, exp, "flags after event");
    end
    pulse(7);
    exp[4] = 1'b0;
    rd(RCFR_ADDR_FLAGS, exp, "flags after wdt clear");
    pulse(3);
    pulse(8, RCFR_PSAVE_IDLE);
    rd(RCFR_ADDR_FLAGS, exp, "flags after power save");
  endtask : t_event_flags
  task t_soft_write;
    wr(RCFR_ADDR_FLAGS, 16'hffff);
    rd(RCFR_ADDR_FLAGS, 16'hc2ff, "flags all set");
    chk("watchdog on", 16'h0001, {15'h0000, wdt_run});
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000, "unmapped read");
    wr(RCFR_ADDR_FLAGS, 16'h0000);
    rd(RCFR_ADDR_FLAGS, 16'h0000, "flags all clear");
    chk("watchdog off", 16'h0000, {15'h0000, wdt_run});
  endtask : t_soft_write
  task t_fuses;
    @(posedge core_clk);
    wdt_fuse <= 2'h3;
    lp_fuse <= 1'b1;
    bor_fuse <= 2'h0;
    wr(RCFR_ADDR_CTRL, 16'h0003);
    repeat (6) @(posedge core_clk);
    #1 chk("enables fuses set", 16'h0008, outs());
    rd(RCFR_ADDR_CTRL, 16'h0003, "ctrl written");
    rd(RCFR_ADDR_STATUS, 16'h0005, "status fuses set");
    @(posedge core_clk);
    wdt_fuse <= 2'h0;
    lp_fuse <= 1'b0;
    bor_fuse <= 2'h1;
    repeat (6) @(posedge core_clk);
    #1 chk("enables soft", 16'h0007, outs());
    rd(RCFR_ADDR_STATUS, 16'h001a, "status soft");
    wr(RCFR_ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 chk("enables off", 16'h0000, outs());
  endtask : t_fuses
  task t_irq;
    rd(RCFR_ADDR_IRQ_STAT, 16'hc2de, "irq status", 16'hfffe);
    rd(RCFR_ADDR_IRQ_STAT, 16'h0000, "irq status cleared", 16'hfffe);
    wr(RCFR_ADDR_IRQ_MASK, 16'h0010);
    rd(RCFR_ADDR_IRQ_MASK, 16'h0010, "irq mask");
    pulse(4);
    #1 chk("irq masked", 16'h0000, {15'h0000, irq});
    pulse(3);
    #1 chk("irq raised", 16'h0001, {15'h0000, irq});
    rd(RCFR_ADDR_IRQ_STAT, 16'h8010, "irq status events", 16'hfffe);
    @(posedge core_clk);
    #1 chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask : t_irq
  // Mid-run power-on reset: outputs drop at once, flags reload, sticky causes go
  task t_por;
    wr(RCFR_ADDR_FLAGS, 16'hc2fc);
    pulse(3);
    #1 chk("irq before reset", 16'h0001, {15'h0000, irq});
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("enables in reset", 16'h0000, outs());
    chk("irq in reset", 16'h0000, {15'h0000, irq});
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(RCFR_ADDR_FLAGS, 16'h0003, "flags after power-on");
    rd(RCFR_ADDR_IRQ_STAT, 16'h0000, "status after power-on");
  endtask : t_por
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_reset_values();
    t_event_flags();
    t_soft_write();
    t_fuses();
    t_irq();
    t_por();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
endmodule : test_rcfr_top
